// ---- core/ecc_routine_regs.vh ----
// Constants of the binary-field routine sequencer.
// Assumes the including file sits under `timescale 1ns/1ps.
// Operation
// - Doubling leaves result X,Y,Z in B1-B3; A3 and B0 unchanged.
// - Doubling never writes A0, A1 or A2.
// - Other operand blocks hold no guaranteed value after a routine.
// - Field add starts at entry 0x008 and adds selected A and B mod N.
// - Binary-field sum is bitwise XOR; it doubles as subtraction.
// - Add result goes into the selected B block.
// - Add applies no Montgomery conversion; same result either form.
// - Montgomery multiply starts at entry 0x00A, shared with prime field.
// - Multiply computes A*B*R^-1 mod N with R = 2^(16*digits).
// - Multiply keeps A, writes product into the selected B block.
// - Multiply also accepts operands outside Montgomery form.
`ifndef ECC_ROUTINE_REGS_VH
`define ECC_ROUTINE_REGS_VH
`define ENTRY_W 12
`define ENTRY_DOUBLE 12'h006
`define ENTRY_ADD 12'h008
`define ENTRY_MUL 12'h00A
`define DIGIT_W 16
`define NUM_DIGITS 4
`define OPND_W 64
`define OPND_TOP 63
`define MSIZE_W 2
`define BLK_A0 4'h0
`define BLK_A3 4'h3
`define BLK_B0 4'h4
`define BLK_B1 4'h5
`define BLK_B2 4'h6
`define BLK_B3 4'h7
`define BLK_N0 4'h8
`define BLK_T0 4'hC
`define BLK_T1 4'hD
`define BLK_T2 4'hE
`define BLK_T3 4'hF
`define ERR_NONE 2'h0
`define ERR_ENTRY 2'h1
`endif

// ---- core/operand_ram.v ----
// Operand memory: sixteen 64-bit blocks, A0-3, B0-3, N0-3, scratch.
// Assumes one clock; read data is registered, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_routine_regs.vh"
module operand_ram (
	input wire mclk,
	input wire we,
	input wire [3:0] waddr,
	input wire [`OPND_TOP:0] wdata,
	input wire [3:0] raddr,
	output reg [`OPND_TOP:0] rdata
);
	reg [`OPND_TOP:0] mem [0:15];

	// No reset: contents are the host's business
	always @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ---- core/gf2_mont_mult.v ----
// Bit-serial binary-field Montgomery multiplier, A*B*x^-W mod N.
// Assumes N has its constant term set (irreducible polynomial).
`timescale 1ns/1ps
`default_nettype none
`include "ecc_routine_regs.vh"
module gf2_mont_mult (
	input wire mclk,
	input wire rst,
	input wire start,
	input wire [`OPND_TOP:0] opa,
	input wire [`OPND_TOP:0] opb,
	input wire [`OPND_TOP:0] modn,
	input wire [`MSIZE_W-1:0] msize,
	output reg done_ff,
	output reg [`OPND_TOP:0] prod_ff
);
	reg [`OPND_TOP:0] a_ff;
	reg [`OPND_TOP:0] b_ff;
	reg [`OPND_TOP:0] n_ff;
	reg [6:0] cnt_ff;
	reg busy_ff;
	reg [`OPND_TOP:0] t;
	reg [6:0] nbits;

	// R = 2^(16*digits); digits = msize+1 in this narrow datapath
	always @* begin
		nbits = {msize, 4'h0} + 7'h10;
		t = prod_ff ^ (a_ff[0] ? b_ff : {`OPND_W{1'b0}});
		// Odd term cancelled by N, then one division by x
		if (t[0]) begin
			t = t ^ n_ff;
		end
		t = {1'b0, t[`OPND_TOP:1]};
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			a_ff <= {`OPND_W{1'b0}};
			b_ff <= {`OPND_W{1'b0}};
			n_ff <= {`OPND_W{1'b0}};
			prod_ff <= {`OPND_W{1'b0}};
			cnt_ff <= 7'h00;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				a_ff <= opa;
				b_ff <= opb;
				n_ff <= modn;
				prod_ff <= {`OPND_W{1'b0}};
				cnt_ff <= nbits;
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				prod_ff <= t;
				a_ff <= {1'b0, a_ff[`OPND_TOP:1]};
				cnt_ff <= cnt_ff - 7'h01;
				if (cnt_ff == 7'h01) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- core/ecc_f2m_routines.v ----
// Routine sequencer: point double, field add, Montgomery multiply.
// Assumes host loads operands through the load port while idle.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_routine_regs.vh"
module ecc_f2m_routines (
	input wire mclk,
	input wire rst,
	input wire start,
	input wire [`ENTRY_W-1:0] entry_addr,
	input wire [1:0] a_sel,
	input wire [1:0] b_sel,
	input wire [1:0] n_sel,
	input wire [`MSIZE_W-1:0] msize,
	input wire coordinate_scheme_select,
	input wire host_we,
	input wire [3:0] host_addr,
	input wire [`OPND_TOP:0] host_wdata,
	output reg [`OPND_TOP:0] host_rdata_ff,
	output reg busy_ff,
	output reg done_ff,
	output reg [1:0] error_ff
);
	localparam S_IDLE = 6'b000001;
	localparam S_RD = 6'b000010;
	localparam S_LAT = 6'b000100;
	localparam S_EXEC = 6'b001000;
	localparam S_WAIT = 6'b010000;
	localparam S_WR = 6'b100000;
	localparam NSTEP = 5'd13;

	reg [5:0] state_ff;
	reg [4:0] step_ff;
	reg [2:0] rph_ff;
	reg [`ENTRY_W-1:0] entry_ff;
	reg [`OPND_TOP:0] ra_ff;
	reg [`OPND_TOP:0] rb_ff;
	reg [`OPND_TOP:0] rn_ff;
	reg mul_go_ff;
	reg scheme_ff;
	reg [3:0] src_a;
	reg [3:0] src_b;
	reg [3:0] dst;
	reg is_mul;
	reg [3:0] raddr;
	reg we;
	reg [3:0] waddr;
	reg [`OPND_TOP:0] wdata;
	wire [`OPND_TOP:0] rdata;
	wire mul_done;
	wire [`OPND_TOP:0] mul_prod;

	////////////////////////////////////////////////////////////////////
	// Doubling program: only B1-B3 and scratch are destinations
	// Lopez-Dahab style: Z3=X^2 Z^2, X3=X^4+c'Z^4, Y3 from a',c'
	always @* begin
		src_a = `BLK_B1;
		src_b = `BLK_B1;
		dst = `BLK_T0;
		is_mul = 1'b1;
		case (step_ff)
			5'd0: begin
				src_a = `BLK_B1; src_b = `BLK_B1; dst = `BLK_T0; // X^2
			end
			5'd1: begin
				src_a = `BLK_B3; src_b = `BLK_B3; dst = `BLK_T1; // Z^2
			end
			5'd2: begin
				src_a = `BLK_T0; src_b = `BLK_T1; dst = `BLK_B3; // Z3
			end
			5'd3: begin
				src_a = `BLK_T1; src_b = `BLK_T1; dst = `BLK_T1; // Z^4
			end
			5'd4: begin
				src_a = `BLK_T0; src_b = `BLK_T0; dst = `BLK_T2; // X^4
			end
			5'd5: begin
				src_a = `BLK_B0; src_b = `BLK_T1; dst = `BLK_T1; // c'Z^4
			end
			5'd6: begin
				src_a = `BLK_T2; src_b = `BLK_T1; dst = `BLK_B1;
				is_mul = 1'b0; // X3 = X^4 + c'Z^4
			end
			5'd7: begin
				src_a = `BLK_B2; src_b = `BLK_B2; dst = `BLK_T0; // Y^2
			end
			5'd8: begin
				src_a = `BLK_A3; src_b = `BLK_B3; dst = `BLK_T2; // a'Z3
			end
			5'd9: begin
				src_a = `BLK_T0; src_b = `BLK_T2; dst = `BLK_T0;
				is_mul = 1'b0;
			end
			5'd10: begin
				src_a = `BLK_T0; src_b = `BLK_T1; dst = `BLK_T0;
				is_mul = 1'b0;
			end
			5'd11: begin
				src_a = `BLK_T0; src_b = `BLK_B1; dst = `BLK_T0;
			end
			5'd12: begin
				src_a = `BLK_T1; src_b = `BLK_B3; dst = `BLK_T3;
			end
			default: begin
				src_a = `BLK_T3; src_b = `BLK_T0; dst = `BLK_B2;
				is_mul = 1'b0; // Y3
			end
		endcase
		if (entry_ff != `ENTRY_DOUBLE) begin
			src_a = {2'b00, a_sel};
			src_b = {2'b01, b_sel};
			dst = {2'b01, b_sel};
			is_mul = (entry_ff == `ENTRY_MUL);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Memory port sharing: host owns it while idle
	always @* begin
		raddr = host_addr;
		if (state_ff == S_RD) begin
			case (rph_ff)
				3'd0: raddr = src_a;
				3'd1: raddr = src_b;
				default: raddr = (entry_ff == `ENTRY_DOUBLE) ?
					`BLK_N0 : {2'b10, n_sel};
			endcase
		end
		we = (state_ff == S_IDLE) & host_we;
		waddr = host_addr;
		wdata = host_wdata;
		if (state_ff == S_WR) begin
			we = 1'b1;
			waddr = dst;
			// XOR: no carry, no reduction, form independent
			wdata = is_mul ? mul_prod : (ra_ff ^ rb_ff);
		end
	end

	operand_ram u_ram (
		.mclk(mclk),
		.we(we),
		.waddr(waddr),
		.wdata(wdata),
		.raddr(raddr),
		.rdata(rdata)
	);

	gf2_mont_mult u_mul (
		.mclk(mclk),
		.rst(rst),
		.start(mul_go_ff),
		.opa(ra_ff),
		.opb(rb_ff),
		.modn(rn_ff),
		.msize(msize),
		.done_ff(mul_done),
		.prod_ff(mul_prod)
	);

	////////////////////////////////////////////////////////////////////
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= S_IDLE;
			step_ff <= 5'd0;
			rph_ff <= 3'd0;
			entry_ff <= {`ENTRY_W{1'b0}};
			ra_ff <= {`OPND_W{1'b0}};
			rb_ff <= {`OPND_W{1'b0}};
			rn_ff <= {`OPND_W{1'b0}};
			mul_go_ff <= 1'b0;
			scheme_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			error_ff <= `ERR_NONE;
			host_rdata_ff <= {`OPND_W{1'b0}};
		end else begin
			mul_go_ff <= 1'b0;
			done_ff <= 1'b0;
			host_rdata_ff <= rdata;
			case (state_ff)
				S_IDLE: begin
					if (start) begin
						entry_ff <= entry_addr;
						scheme_ff <= coordinate_scheme_select;
						step_ff <= 5'd0;
						if (entry_addr == `ENTRY_DOUBLE ||
							entry_addr == `ENTRY_ADD ||
							entry_addr == `ENTRY_MUL) begin
							state_ff <= S_RD;
							rph_ff <= 3'd0;
							busy_ff <= 1'b1;
							error_ff <= `ERR_NONE;
						end else begin
							error_ff <= `ERR_ENTRY;
							done_ff <= 1'b1;
						end
					end
				end
				S_RD: begin
					// Registered read: data lands a cycle late
					rph_ff <= rph_ff + 3'd1;
					if (rph_ff == 3'd1) ra_ff <= rdata;
					if (rph_ff == 3'd2) rb_ff <= rdata;
					if (rph_ff == 3'd2) state_ff <= S_LAT;
				end
				S_LAT: begin
					rn_ff <= rdata;
					state_ff <= S_EXEC;
				end
				S_EXEC: begin
					if (is_mul) begin
						mul_go_ff <= 1'b1;
						state_ff <= S_WAIT;
					end else begin
						state_ff <= S_WR;
					end
				end
				S_WAIT: begin
					if (mul_done) state_ff <= S_WR;
				end
				S_WR: begin
					if (entry_ff == `ENTRY_DOUBLE && step_ff != NSTEP) begin
						step_ff <= step_ff + 5'd1;
						rph_ff <= 3'd0;
						state_ff <= S_RD;
					end else begin
						state_ff <= S_IDLE;
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
					end
				end
				default: begin
					state_ff <= S_IDLE;
					busy_ff <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- test/ecc_monitor.sv ----
// Handshake checker for the routine sequencer outputs.
// Assumes binding into ecc_f2m_routines; one clock, rst async high.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_routine_regs.vh"
module ecc_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic [`ENTRY_W-1:0] entry_addr,
	input wire logic busy_ff,
	input wire logic done_ff,
	input wire logic [1:0] error_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic take = start && !busy_ff;
	wire logic is_add = entry_addr == `ENTRY_ADD;
	wire logic is_mul = entry_addr == `ENTRY_MUL;
	wire logic is_dbl = entry_addr == `ENTRY_DOUBLE;
	wire logic known = is_add || is_mul || is_dbl;
	////////////////////////////////////////
	property p_go; take && known |=> busy_ff && !done_ff; endproperty
	a_go: assert property (p_go) else $error("start not taken");
	property p_idle; !take && !busy_ff |=> !busy_ff && !done_ff; endproperty
	a_idle: assert property (p_idle) else $error("not idle");
	property p_bad; take && !known |=> done_ff && error_ff == `ERR_ENTRY;
	endproperty
	a_bad: assert property (p_bad) else $error("bad entry");
	property p_add; take && is_add |-> ##[6:8] done_ff; endproperty
	a_add: assert property (p_add) else $error("add late");
	property p_mul; take && is_mul |-> ##[8:80] done_ff; endproperty
	a_mul: assert property (p_mul) else $error("mul late");
	property p_dbl; take && is_dbl |-> ##[14:1000] done_ff; endproperty
	a_dbl: assert property (p_dbl) else $error("double late");
	property p_pulse; done_ff |=> !done_ff; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_fell; $fell(busy_ff) |-> done_ff; endproperty
	a_fell: assert property (p_fell) else $error("busy fell");
	property p_err; !take |=> $stable(error_ff); endproperty
	a_err: assert property (p_err) else $error("error moved");
endmodule
bind ecc_f2m_routines ecc_monitor u_mon (.mclk, .rst, .start,
	.entry_addr, .busy_ff, .done_ff, .error_ff);
`default_nettype wire

// ---- test/host_model.sv ----
// Host side: operand loads, block pointers, routine start.
// Assumes callers are the bench; requests go out 1 ns past an edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic mclk,
	input wire logic done_ff,
	input wire logic [63:0] host_rdata_ff,
	output logic start,
	output logic [11:0] entry_addr,
	output logic [1:0] a_sel,
	output logic [1:0] b_sel,
	output logic [1:0] n_sel,
	output logic [1:0] msize,
	output logic coordinate_scheme_select,
	output logic host_we,
	output logic [3:0] host_addr,
	output logic [63:0] host_wdata
);
	initial begin
		{start, entry_addr, a_sel, b_sel, n_sel, msize} = '0;
		{coordinate_scheme_select, host_we, host_addr, host_wdata} = '0;
	end
	task wr(input logic [3:0] a, input logic [63:0] d);
		@(posedge mclk);
		#1;
		{host_we, host_addr, host_wdata} = {1'b1, a, d};
		@(posedge mclk);
		#1;
		host_we = 0;
		// Stale data would hide a missed strobe
		host_wdata = ~d;
	endtask
	task rd(input logic [3:0] a, output logic [63:0] d);
		@(posedge mclk);
		#1;
		host_addr = a;
		@(posedge mclk);
		@(posedge mclk);
		#1;
		d = host_rdata_ff;
	endtask
	task go(input logic [11:0] e, input logic [1:0] as, bs, m);
		int n;
		@(posedge mclk);
		#1;
		{entry_addr, a_sel, b_sel, n_sel} = {e, as, bs, 2'h0};
		msize = m;
		coordinate_scheme_select = 1;
		start = 1;
		@(posedge mclk);
		#1;
		start = 0;
		n = 0;
		// Look past the edge so the one-cycle done pulse is settled
		while (done_ff !== 1'b1 && n < 2000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		#1;
	endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench of the binary-field routine sequencer.
// Assumes host_model drives every design input except mclk and rst, which this bench drives.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_routine_regs.vh"
module tb_top;
	logic mclk, rst, start, coordinate_scheme_select, host_we;
	logic [11:0] entry_addr;
	logic [1:0] a_sel, b_sel, n_sel, msize, error_ff;
	logic [3:0] host_addr;
	logic [63:0] host_wdata, host_rdata_ff, d;
	logic busy_ff, done_ff;
	int failures, cmp_count;
	typedef struct packed {
		logic [1:0] as, bs;
		logic [63:0] a, b, c;
	} row_t;
	row_t rows [3] = '{
		'{2'h0, 2'h0, 64'hF0, 64'hFF0, 64'hF00},
		'{2'h1, 2'h2, 64'h5A5A, 64'h5A5A, 64'h0},
		'{2'h3, 2'h3, 64'h8000000000000001, 64'h1, 64'h8000000000000000}
	};
	host_model host (.mclk, .done_ff, .host_rdata_ff, .start, .entry_addr,
		.a_sel, .b_sel, .n_sel, .msize, .coordinate_scheme_select,
		.host_we, .host_addr, .host_wdata);
	ecc_f2m_routines dut (.mclk, .rst, .start, .entry_addr, .a_sel,
		.b_sel, .n_sel, .msize, .coordinate_scheme_select, .host_we,
		.host_addr, .host_wdata, .host_rdata_ff, .busy_ff, .done_ff,
		.error_ff);
	task chk(input string nm, input logic [63:0] e, s);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	task summarize;
		if (failures == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// Longest path is the doubling, far below this span
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		summarize();
	end
	////////////////////////////////////////
	initial begin
		rst = 1;
		repeat (4) @(posedge mclk);
		chk("reset", 0, {60'h0, busy_ff, done_ff, error_ff});
		#1 rst = 0;
		host.wr(4'h8, '1);
		foreach (rows[i]) begin
			host.wr({2'h0, rows[i].as}, rows[i].a);
			host.wr({2'h1, rows[i].bs}, rows[i].b);
			host.go(`ENTRY_ADD, rows[i].as, rows[i].bs, 2'h3);
			host.rd({2'h1, rows[i].bs}, d);
			chk("sum", rows[i].c, d);
		end
		host.wr(4'h1, 64'h1234);
		host.wr(4'h6, '0);
		host.go(`ENTRY_MUL, 2'h1, 2'h2, 2'h3);
		host.rd(4'h6, d);
		chk("prod", 0, d);
		host.rd(4'h1, d);
		chk("mul a", 64'h1234, d);
		host.wr(4'h0, '0);
		host.wr(4'h5, 64'h77);
		host.go(`ENTRY_MUL, 2'h0, 2'h1, 2'h0);
		host.rd(4'h5, d);
		chk("prod0", 0, d);
		for (int i = 0; i < 9; i++)
			host.wr(i[3:0], {60'h0, i[3:0]} + 64'h101);
		host.go(`ENTRY_DOUBLE, 2'h0, 2'h0, 2'h3);
		for (int i = 0; i < 5; i++) begin
			host.rd(i[3:0], d);
			chk("keep", {60'h0, i[3:0]} + 64'h101, d);
		end
		host.go(12'h00B, 2'h0, 2'h0, 2'h3);
		chk("err", `ERR_ENTRY, {62'h0, error_ff});
		fork
			host.go(`ENTRY_ADD, 2'h0, 2'h0, 2'h3);
			begin
				repeat (3) @(posedge mclk);
				host.wr(4'h0, 64'hBAD);
			end
		join
		chk("err clr", 0, {62'h0, error_ff});
		host.rd(4'h4, d);
		chk("sum b0", 64'h4, d);
		host.rd(4'h0, d);
		chk("refused", 64'h101, d);
		fork
			host.go(`ENTRY_DOUBLE, 2'h0, 2'h0, 2'h3);
		join_none
		repeat (5) @(posedge mclk);
		#2 rst = 1;
		#1 chk("abort", 0, {63'h0, busy_ff});
		repeat (2) @(posedge mclk);
		#1 rst = 0;
		repeat (3) @(posedge mclk);
		summarize();
	end
endmodule
`default_nettype wire
